// >>> rtl/apm_pkg.sv
// shared constants and types for the analyzer panel memory controller
package apm_pkg;

  // ----------------------------------------------------------------------
  // dimensions
  // ----------------------------------------------------------------------
  localparam int NUM_BANDS = 30;
  localparam int NUM_SLOTS = 6;
  localparam int LEVEL_W = 8;
  localparam int AVG_MAX = 256;
  localparam int SUM_W = 17;
  localparam logic [2:0] LAST_SLOT = 3'h5;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam longint CLOCK_HZ = 25000000;
  localparam int HOLD_MS = 1000;
  localparam int HOLD_CYCLES = int'(CLOCK_HZ * HOLD_MS / 1000);
  localparam int DEBOUNCE_US = 10000;
  localparam int DEBOUNCE_CYCLES = int'(CLOCK_HZ * DEBOUNCE_US / 1000000);
  localparam int FLASH_MS = 250;
  localparam int FLASH_CYCLES = int'(CLOCK_HZ * FLASH_MS / 1000);
  localparam int SLOW_FLASH_MS = 1000;
  localparam int SLOW_FLASH_CYCLES = int'(CLOCK_HZ * SLOW_FLASH_MS / 1000);

  // ----------------------------------------------------------------------
  // register map (plain port, word index)
  // ----------------------------------------------------------------------
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CONTROL = 4'h1;
  localparam logic [3:0] REG_SLOT = 4'h2;
  localparam logic [3:0] REG_AVG_COUNT = 4'h3;
  localparam logic [3:0] REG_LEVEL_PEAK = 4'h4;
  localparam logic [3:0] REG_INDICATORS = 4'h5;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam int CTRL_CONTEST = 0;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    VIEW_LIVE, VIEW_FROZEN, VIEW_REVIEW, VIEW_PEAK, VIEW_AVG_SEL
  } apm_view_e;

  typedef enum logic [1:0] {
    PR_IDLE, PR_HEADER, PR_BANDS, PR_DONE
  } apm_print_e;

  typedef struct packed {
    logic tap;
    logic hold;
  } apm_press_s;

  typedef struct packed {
    logic last_slot;
    logic review;
    logic analyzer;
    logic level;
    logic battery;
    logic charge;
  } apm_leds_s;

endpackage : apm_pkg

// >>> rtl/apm_button.sv
// debounce and press classification for one panel button
`timescale 1ns/1ps
module apm_button
  import apm_pkg::*;
#(
  parameter int DEB_CYCLES = DEBOUNCE_CYCLES,
  parameter int HOLD_CNT = HOLD_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic raw,
  output apm_press_s press,
  output logic level
);

  logic [24:0] deb_cnt;
  logic [24:0] hold_cnt;
  logic held;

  // debounce: accept a new level only after it stays stable
  always_ff @(posedge clk) begin
    if (srst) begin
      deb_cnt <= '0;
      level <= 1'b0;
    end else if (raw == level) begin
      deb_cnt <= '0;
    end else if (deb_cnt >= 25'(DEB_CYCLES - 1)) begin
      deb_cnt <= '0;
      level <= raw;
    end else begin
      deb_cnt <= deb_cnt + 25'h1;
    end
  end

  // short tap on release before one second, hold once at one second
  always_ff @(posedge clk) begin
    if (srst) begin
      hold_cnt <= '0;
      held <= 1'b0;
      press <= '0;
    end else begin
      press <= '0;
      if (level) begin
        if (!held && hold_cnt >= 25'(HOLD_CNT - 1)) begin
          held <= 1'b1;
          press.hold <= 1'b1;
        end else if (!held) begin
          hold_cnt <= hold_cnt + 25'h1;
        end
      end else begin
        if (hold_cnt != '0 && !held) begin
          press.tap <= 1'b1;
        end
        hold_cnt <= '0;
        held <= 1'b0;
      end
    end
  end

endmodule : apm_button

// >>> rtl/apm_panel.sv
// front panel, curve memory, averaging, peak hold and print control
//
// Notes on behaviour
// - view button tap from live shows stored curves, review indicator lit.
// - memory tap in review steps through six slots and shows each.
// - view button tap in review returns to live analysis.
// - average of up to 256 picks is written into slot six.
// - capture hold starts averaging; last-slot indicator flashes.
// - capture tap in averaging adds current slot; repeats add weight.
// - second capture hold averages, shows, stores slot six, indicator steady.
// - view hold enters peak hold, analyzer flashes, bands keep maximum.
// - view tap during peak hold leaves peak hold.
// - peak-hold curve is an ordinary display, storable and averageable.
// - view hold in level readout mode enables numeric level peak hold.
// - capture held at power-up erases all curve memories.
// - print tap sends shown curve, recalled or frozen, to printer.
// - plain parallel byte output, no printer control codes.
// - printout opens with a form code byte; contest format when selected.
// - battery indicator flashes when about 30 minutes remain.
// - charging while off: charge light steady, slow flash when full.
// - first capture tap freezes; second stores into slot, enters review.
// - curves are stored at the finest one-step resolution always.
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module apm_panel
  import apm_pkg::*;
#(
  parameter int DEB_CYCLES = DEBOUNCE_CYCLES,
  parameter int HOLD_CNT = HOLD_CYCLES,
  parameter int FLASH_CNT = FLASH_CYCLES,
  parameter int SLOW_CNT = SLOW_FLASH_CYCLES
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic SRST,
  // panel buttons, high while pressed
  input wire logic CAPTURE_BUTTON,
  input wire logic VIEW_TOGGLE_BUTTON,
  input wire logic MEMORY_BUTTON,
  input wire logic LEVEL_READOUT_BUTTON,
  input wire logic PRINT_BUTTON,
  // live analysis, one band per cycle in finest steps
  input wire logic BAND_VALID,
  input wire logic [4:0] BAND_INDEX,
  input wire logic [LEVEL_W-1:0] BAND_LEVEL,
  input wire logic [LEVEL_W-1:0] LEVEL_READING,
  // power state
  input wire logic BATTERY_LOW,
  input wire logic CHARGING,
  input wire logic CHARGE_FULL,
  // register port
  input wire logic [3:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  // display readout
  input wire logic [4:0] DISP_BAND,
  output logic [LEVEL_W-1:0] DISP_LEVEL,
  output logic [LEVEL_W-1:0] LEVEL_SHOWN,
  // indicators
  output apm_leds_s LEDS,
  // parallel printer
  input wire logic PRN_BUSY,
  output logic [7:0] PRN_DATA,
  output logic PRN_STROBE_N
);

  // ----------------------------------------------------------------------
  // buttons
  // ----------------------------------------------------------------------
  apm_press_s cap, vt, mem, lvl, prn;

  apm_button #(.DEB_CYCLES(DEB_CYCLES), .HOLD_CNT(HOLD_CNT)) u_cap (
    .clk(CLOCK), .srst(SRST), .raw(CAPTURE_BUTTON), .press(cap),
    .level());
  apm_button #(.DEB_CYCLES(DEB_CYCLES), .HOLD_CNT(HOLD_CNT)) u_vt (
    .clk(CLOCK), .srst(SRST), .raw(VIEW_TOGGLE_BUTTON), .press(vt),
    .level());
  apm_button #(.DEB_CYCLES(DEB_CYCLES), .HOLD_CNT(HOLD_CNT)) u_mem (
    .clk(CLOCK), .srst(SRST), .raw(MEMORY_BUTTON), .press(mem),
    .level());
  apm_button #(.DEB_CYCLES(DEB_CYCLES), .HOLD_CNT(HOLD_CNT)) u_lvl (
    .clk(CLOCK), .srst(SRST), .raw(LEVEL_READOUT_BUTTON), .press(lvl),
    .level());
  apm_button #(.DEB_CYCLES(DEB_CYCLES), .HOLD_CNT(HOLD_CNT)) u_prn (
    .clk(CLOCK), .srst(SRST), .raw(PRINT_BUTTON), .press(prn),
    .level());

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  logic [LEVEL_W-1:0] curves [NUM_SLOTS][NUM_BANDS];
  logic [LEVEL_W-1:0] shown [NUM_BANDS];
  logic [SUM_W-1:0] sums [NUM_BANDS];
  apm_view_e view;
  logic [2:0] slot;
  logic [8:0] avg_count;
  logic [7:0] control;
  logic level_mode;
  logic level_peak;
  logic [LEVEL_W-1:0] level_held;
  logic [4:0] band_ptr;
  logic clearing;
  logic storing;
  logic adding;
  logic dividing;
  logic [2:0] store_slot;
  logic startup;

  function automatic logic [2:0] next_slot_of(input logic [2:0] s);
    next_slot_of = (s == LAST_SLOT) ? 3'h0 : s + 3'h1;
  endfunction : next_slot_of

  // ----------------------------------------------------------------------
  // view mode sequencing
  // ----------------------------------------------------------------------
  logic busy;
  assign busy = clearing | storing | adding | dividing;

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      view <= VIEW_LIVE;
      slot <= 3'h0;
      avg_count <= 9'h0;
      storing <= 1'b0;
      adding <= 1'b0;
      dividing <= 1'b0;
      store_slot <= 3'h0;
      band_ptr <= 5'h0;
    end else if (busy && !clearing) begin
      // band-serial walks for store, add and divide
      band_ptr <= (band_ptr == 5'(NUM_BANDS - 1)) ? 5'h0 : band_ptr + 5'h1;
      if (band_ptr == 5'(NUM_BANDS - 1)) begin
        storing <= 1'b0;
        adding <= 1'b0;
        if (dividing) begin
          dividing <= 1'b0;
          storing <= 1'b1;
          store_slot <= LAST_SLOT;
          view <= VIEW_REVIEW;
          slot <= LAST_SLOT;
        end
      end
    end else if (!clearing) begin
      unique case (view)
        VIEW_LIVE: begin
          if (vt.hold && !level_mode) view <= VIEW_PEAK;
          else if (vt.tap && !level_mode) view <= VIEW_REVIEW;
          else if (cap.tap) view <= VIEW_FROZEN;
          else if (cap.hold) begin
            view <= VIEW_AVG_SEL;
            avg_count <= 9'h0;
          end
        end
        VIEW_FROZEN: begin
          if (mem.tap) slot <= next_slot_of(slot);
          else if (cap.tap) begin
            storing <= 1'b1;
            store_slot <= slot;
            view <= VIEW_REVIEW;
          end else if (vt.tap) view <= VIEW_LIVE;
        end
        VIEW_REVIEW: begin
          if (mem.tap) slot <= next_slot_of(slot);
          else if (vt.tap) view <= VIEW_LIVE;
          else if (cap.hold) begin
            view <= VIEW_AVG_SEL;
            avg_count <= 9'h0;
          end
        end
        VIEW_PEAK: begin
          if (vt.tap) view <= VIEW_LIVE;
          else if (cap.tap) view <= VIEW_FROZEN;
        end
        VIEW_AVG_SEL: begin
          if (mem.tap) slot <= next_slot_of(slot);
          else if (cap.tap && avg_count != 9'(AVG_MAX)) begin
            adding <= 1'b1;
            avg_count <= avg_count + 9'h1;
          end else if (cap.hold) begin
            if (avg_count != 9'h0) dividing <= 1'b1;
            else view <= VIEW_REVIEW;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // curve data path
  // ----------------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      clearing <= 1'b0;
      startup <= 1'b1;
      for (int b = 0; b < NUM_BANDS; b++) begin
        shown[b] <= '0;
        sums[b] <= '0;
      end
    end else begin
      startup <= 1'b0;
      if (startup && CAPTURE_BUTTON) clearing <= 1'b1;
      if (clearing) begin
        for (int s = 0; s < NUM_SLOTS; s++)
          for (int b = 0; b < NUM_BANDS; b++)
            curves[s][b] <= '0;
        clearing <= 1'b0;
      end else if (storing) begin
        curves[store_slot][band_ptr] <= shown[band_ptr];
      end else if (adding) begin
        sums[band_ptr] <= sums[band_ptr]
          + SUM_W'(curves[slot][band_ptr]);
      end else if (dividing) begin
        shown[band_ptr] <= LEVEL_W'(sums[band_ptr]
          / SUM_W'(avg_count));
        sums[band_ptr] <= '0;
      end else if (view == VIEW_AVG_SEL && avg_count == 9'h0) begin
        for (int b = 0; b < NUM_BANDS; b++) sums[b] <= '0;
        shown <= curves[slot];
      end else if (view == VIEW_REVIEW || view == VIEW_AVG_SEL) begin
        shown <= curves[slot];
      end else if (BAND_VALID && view == VIEW_LIVE) begin
        shown[BAND_INDEX] <= BAND_LEVEL;
      end else if (BAND_VALID && view == VIEW_PEAK) begin
        if (BAND_LEVEL > shown[BAND_INDEX])
          shown[BAND_INDEX] <= BAND_LEVEL;
      end
    end
  end

  // ----------------------------------------------------------------------
  // numeric level readout and peak
  // ----------------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      level_mode <= 1'b0;
      level_peak <= 1'b0;
      level_held <= '0;
    end else begin
      if (lvl.hold) begin
        level_mode <= ~level_mode;
        level_peak <= 1'b0;
      end
      if (level_mode && vt.hold) level_peak <= 1'b1;
      else if (level_mode && vt.tap) level_peak <= 1'b0;
      if (!level_peak) level_held <= LEVEL_READING;
      else if (LEVEL_READING > level_held)
        level_held <= LEVEL_READING;
    end
  end

  // ----------------------------------------------------------------------
  // indicators
  // ----------------------------------------------------------------------
  logic [23:0] flash_cnt;
  logic [24:0] slow_cnt;
  logic flash;
  logic slow;

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      flash_cnt <= '0;
      slow_cnt <= '0;
      flash <= 1'b0;
      slow <= 1'b0;
    end else begin
      flash_cnt <= (flash_cnt >= 24'(FLASH_CNT - 1)) ? '0
        : flash_cnt + 24'h1;
      if (flash_cnt >= 24'(FLASH_CNT - 1)) flash <= ~flash;
      slow_cnt <= (slow_cnt >= 25'(SLOW_CNT - 1)) ? '0 : slow_cnt + 25'h1;
      if (slow_cnt >= 25'(SLOW_CNT - 1)) slow <= ~slow;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      LEDS <= '0;
    end else begin
      LEDS.last_slot <= (view == VIEW_AVG_SEL) ? flash
        : (view == VIEW_REVIEW && slot == LAST_SLOT);
      LEDS.review <= (view == VIEW_REVIEW);
      LEDS.analyzer <= (view == VIEW_PEAK) ? flash : (view == VIEW_LIVE);
      LEDS.level <= level_peak ? flash : level_mode;
      LEDS.battery <= BATTERY_LOW & flash;
      LEDS.charge <= CHARGING & (CHARGE_FULL ? slow : 1'b1);
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      DISP_LEVEL <= '0;
      LEVEL_SHOWN <= '0;
    end else begin
      DISP_LEVEL <= shown[DISP_BAND];
      LEVEL_SHOWN <= level_held;
    end
  end

  // ----------------------------------------------------------------------
  // printer: one header byte, then one byte per band, strobe per byte
  // ----------------------------------------------------------------------
  apm_print_e pstate;
  logic [4:0] pidx;
  logic pphase;

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      pstate <= PR_IDLE;
      pidx <= 5'h0;
      pphase <= 1'b0;
      PRN_DATA <= 8'h00;
      PRN_STROBE_N <= 1'b1;
    end else begin
      unique case (pstate)
        PR_IDLE: begin
          PRN_STROBE_N <= 1'b1;
          if (prn.tap && (view == VIEW_REVIEW || view == VIEW_FROZEN
              || view == VIEW_PEAK)) begin
            pstate <= PR_HEADER;
            pidx <= 5'h0;
          end
        end
        PR_HEADER: begin
          if (!pphase && !PRN_BUSY) begin
            // form code: plain text form or contest layout
            PRN_DATA <= control[CTRL_CONTEST] ? 8'h43 : 8'h46;
            PRN_STROBE_N <= 1'b0;
            pphase <= 1'b1;
          end else if (pphase) begin
            PRN_STROBE_N <= 1'b1;
            pphase <= 1'b0;
            pstate <= PR_BANDS;
          end
        end
        PR_BANDS: begin
          if (!pphase && !PRN_BUSY) begin
            PRN_DATA <= 8'(shown[pidx]);
            PRN_STROBE_N <= 1'b0;
            pphase <= 1'b1;
          end else if (pphase) begin
            PRN_STROBE_N <= 1'b1;
            pphase <= 1'b0;
            if (pidx == 5'(NUM_BANDS - 1)) pstate <= PR_DONE;
            else pidx <= pidx + 5'h1;
          end
        end
        PR_DONE: pstate <= PR_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      control <= CONTROL_RESET;
    end else if (REG_WR && REG_ADDR == REG_CONTROL) begin
      control <= REG_WDATA[7:0];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      REG_RDATA <= 32'h0;
    end else if (REG_RD) begin
      unique case (REG_ADDR)
        REG_STATUS: REG_RDATA <= {25'h0, busy, pstate != PR_IDLE,
          level_peak, level_mode, view};
        REG_CONTROL: REG_RDATA <= {24'h0, control};
        REG_SLOT: REG_RDATA <= {29'h0, slot};
        REG_AVG_COUNT: REG_RDATA <= {23'h0, avg_count};
        REG_LEVEL_PEAK: REG_RDATA <= 32'(level_held);
        REG_INDICATORS: REG_RDATA <= {26'h0, LEDS};
        default: REG_RDATA <= 32'h0;
      endcase
    end else begin
      REG_RDATA <= 32'h0;
    end
  end

endmodule : apm_panel

// >>> bench/apm_panel_assertions.sv
// port assertions for the panel controller
`timescale 1ns/1ps
module apm_panel_assertions
  import apm_pkg::*;
#(
  parameter int SLOW_CNT = SLOW_FLASH_CYCLES
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic SRST,
  // register port and power state
  input wire logic REG_RD,
  input wire logic [3:0] REG_ADDR,
  input wire logic [31:0] REG_RDATA,
  input wire logic BATTERY_LOW,
  input wire logic CHARGING,
  input wire logic CHARGE_FULL,
  // indicators and printer
  input wire apm_leds_s LEDS,
  input wire logic PRN_BUSY,
  input wire logic PRN_STROBE_N
);
  // ----------------------------------------------------------------
  // run lengths of an unchanged indicator that ought to flash
  // ----------------------------------------------------------------
  int chg_run;
  int bat_run;
  logic chg_prev;
  logic bat_prev;
  logic chg_fl;
  logic bat_fl;
  assign chg_fl = CHARGING && CHARGE_FULL && LEDS.charge == chg_prev;
  assign bat_fl = BATTERY_LOW && LEDS.battery == bat_prev;
  always_ff @(posedge CLOCK) begin
    chg_prev <= LEDS.charge;
    chg_run <= (SRST || !chg_fl) ? 0 : chg_run + 1;
  end
  always_ff @(posedge CLOCK) begin
    bat_prev <= LEDS.battery;
    bat_run <= (SRST || !bat_fl) ? 0 : bat_run + 1;
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);
  sequence chg_on;
    (CHARGING && !CHARGE_FULL) [*3];
  endsequence
  sequence bat_ok;
    !BATTERY_LOW [*3];
  endsequence

  rdata_idle_a: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
    else $error("read data outside its answer cycle");
  slot_range_a: assert property (
    $past(REG_RD) && $past(REG_ADDR) == REG_SLOT |-> REG_RDATA <= 32'h5)
    else $error("slot number beyond six slots");
  strobe_pulse_a: assert property (
    $fell(PRN_STROBE_N) |=> PRN_STROBE_N)
    else $error("printer strobe longer than one cycle");
  strobe_ready_a: assert property (
    $fell(PRN_STROBE_N) |-> !$past(PRN_BUSY))
    else $error("printer strobe while printer busy");
  charge_steady_a: assert property (chg_on |-> LEDS.charge)
    else $error("charge light not steady while charging");
  charge_flash_a: assert property (chg_run <= 2 * SLOW_CNT + 2)
    else $error("charge light not flashing when full");
  batt_flash_a: assert property (bat_run <= 2 * SLOW_CNT + 2)
    else $error("battery light not flashing when low");
  batt_off_a: assert property (bat_ok |-> !LEDS.battery)
    else $error("battery light on without low battery");
endmodule : apm_panel_assertions

bind apm_panel apm_panel_assertions #(.SLOW_CNT(SLOW_CNT))
    u_apm_panel_assertions (
  .CLOCK(CLOCK), .SRST(SRST), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
  .REG_RDATA(REG_RDATA), .BATTERY_LOW(BATTERY_LOW), .CHARGING(CHARGING),
  .CHARGE_FULL(CHARGE_FULL), .LEDS(LEDS), .PRN_BUSY(PRN_BUSY),
  .PRN_STROBE_N(PRN_STROBE_N)
);

// >>> bench/apm_printer_model.sv
// parallel printer model: takes strobed bytes, answers busy
`timescale 1ns/1ps
module apm_printer_model (
  // printer port
  input wire logic clk,
  input wire logic strobe_n,
  input wire logic [7:0] data,
  output logic busy,
  // bench side
  input wire logic clear,
  input wire logic [7:0] busy_len,
  output logic [7:0] n_bytes,
  output logic [7:0] first_byte,
  output logic [7:0] last_byte
);
  logic [7:0] left = 8'h00;
  initial busy = 1'b0;
  initial n_bytes = 8'h00;
  always @(posedge clk) begin
    if (clear) begin
      n_bytes <= 8'h00;
    end else if (!strobe_n) begin
      if (n_bytes == 8'h00) first_byte <= data;
      last_byte <= data;
      n_bytes <= n_bytes + 8'h01;
    end
  end
  // busy after each byte for busy_len cycles, zero answers at once
  always @(posedge clk) begin
    if (!strobe_n && busy_len != 8'h00) begin
      busy <= 1'b1;
      left <= busy_len;
    end else if (left > 8'h01) begin
      left <= left - 8'h01;
    end else begin
      busy <= 1'b0;
      left <= 8'h00;
    end
  end
endmodule : apm_printer_model

// >>> bench/apm_panel_tb.sv
// self-checking bench for the panel controller
`timescale 1ns/1ps
module apm_panel_tb;
  import apm_pkg::*;
  localparam int TAP = 8;
  localparam int HOLD = 30;
  logic CLOCK = 1'b0;
  logic SRST = 1'b1;
  logic [4:0] btn = 5'h00;
  logic [7:0] base = 8'h0a;
  logic [7:0] bidx = 8'h00;
  logic [4:0] BAND_INDEX = 5'h00;
  logic [7:0] BAND_LEVEL = 8'h00;
  logic [7:0] LEVEL_READING = 8'h00;
  logic BATTERY_LOW = 1'b0;
  logic CHARGING = 1'b0;
  logic CHARGE_FULL = 1'b0;
  logic [3:0] REG_ADDR = 4'h0;
  logic [31:0] REG_WDATA = 32'h0;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [4:0] DISP_BAND = 5'h00;
  logic clear = 1'b0;
  logic [7:0] busy_len = 8'h00;
  logic [31:0] REG_RDATA;
  logic [7:0] DISP_LEVEL;
  logic [7:0] LEVEL_SHOWN;
  apm_leds_s LEDS;
  logic PRN_BUSY;
  logic [7:0] PRN_DATA;
  logic PRN_STROBE_N;
  logic [7:0] n_bytes;
  logic [7:0] first_byte;
  logic [7:0] last_byte;
  int n_fail = 0;
  int n_tests = 0;

  always #20 CLOCK = ~CLOCK;
  // live bands: level is base plus band number
  always @(posedge CLOCK) begin
    bidx <= (bidx == 8'h1d) ? 8'h00 : bidx + 8'h01;
    BAND_INDEX <= bidx[4:0];
    BAND_LEVEL <= base + bidx;
  end

  apm_panel #(.DEB_CYCLES(2), .HOLD_CNT(20), .FLASH_CNT(4), .SLOW_CNT(8))
      u_apm_panel (
    .CLOCK(CLOCK), .SRST(SRST), .CAPTURE_BUTTON(btn[0]),
    .VIEW_TOGGLE_BUTTON(btn[1]), .MEMORY_BUTTON(btn[2]),
    .LEVEL_READOUT_BUTTON(btn[3]), .PRINT_BUTTON(btn[4]),
    .BAND_VALID(1'b1), .BAND_INDEX(BAND_INDEX), .BAND_LEVEL(BAND_LEVEL),
    .LEVEL_READING(LEVEL_READING), .BATTERY_LOW(BATTERY_LOW),
    .CHARGING(CHARGING), .CHARGE_FULL(CHARGE_FULL), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .DISP_BAND(DISP_BAND), .DISP_LEVEL(DISP_LEVEL),
    .LEVEL_SHOWN(LEVEL_SHOWN), .LEDS(LEDS), .PRN_BUSY(PRN_BUSY),
    .PRN_DATA(PRN_DATA), .PRN_STROBE_N(PRN_STROBE_N)
  );
  apm_printer_model u_apm_printer_model (
    .clk(CLOCK), .strobe_n(PRN_STROBE_N), .data(PRN_DATA), .busy(PRN_BUSY),
    .clear(clear), .busy_len(busy_len), .n_bytes(n_bytes),
    .first_byte(first_byte), .last_byte(last_byte)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    if (n_fail == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic press(input int i, input int len);
    @(posedge CLOCK);
    btn[i] <= 1'b1;
    repeat (len) @(posedge CLOCK);
    btn[i] <= 1'b0;
    repeat (45) @(posedge CLOCK);
  endtask : press

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge CLOCK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLOCK);
    REG_RD <= 1'b0;
    #1;
    d = REG_RDATA;
  endtask : rd

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLOCK);
    REG_WR <= 1'b0;
  endtask : wr

  task automatic chk_reg(input logic [3:0] a, input logic [31:0] m,
                         input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    check(d & m, e);
  endtask : chk_reg

  task automatic view(input apm_view_e e);
    chk_reg(REG_STATUS, 32'h7, 32'(e));
  endtask : view

  task automatic disp(input logic [4:0] b, input logic [7:0] e);
    @(posedge CLOCK);
    DISP_BAND <= b;
    repeat (2) @(posedge CLOCK);
    #1;
    check(32'(DISP_LEVEL), 32'(e));
  endtask : disp

  task automatic go_slot(input logic [2:0] s);
    logic [31:0] d;
    for (int i = 0; i < 6; i++) begin
      rd(REG_SLOT, d);
      if (d[2:0] == s) break;
      press(2, TAP);
    end
    chk_reg(REG_SLOT, 32'h7, 32'(s));
  endtask : go_slot

  task automatic flashing(input int f, input logic e);
    logic first;
    logic moved;
    #1;
    first = LEDS[f];
    moved = 1'b0;
    repeat (20) begin
      @(posedge CLOCK);
      #1;
      if (LEDS[f] !== first) moved = 1'b1;
    end
    check(32'(moved), 32'(e));
  endtask : flashing

  task automatic print_once(input logic [7:0] blen, input logic [7:0] hdr);
    int k;
    @(posedge CLOCK);
    busy_len <= blen;
    clear <= 1'b1;
    @(posedge CLOCK);
    clear <= 1'b0;
    press(4, TAP);
    for (k = 0; k < 3000 && n_bytes != 8'h1f; k++) @(posedge CLOCK);
    if (k == 3000) begin
      n_fail++;
      stop_test();
    end
    repeat (40) @(posedge CLOCK);
    check(32'(n_bytes), 32'h1f);
    check(32'(first_byte), 32'(hdr));
    check(32'(last_byte), 32'h27);
  endtask : print_once

  task automatic s_erase();
    view(VIEW_LIVE);
    chk_reg(REG_CONTROL, 32'hff, 32'(CONTROL_RESET));
    chk_reg(4'hf, 32'hffffffff, 32'h0);
    press(1, TAP);
    disp(5'h07, 8'h00);
    press(1, TAP);
  endtask : s_erase

  task automatic s_store();
    press(0, TAP);
    view(VIEW_FROZEN);
    press(0, TAP);
    view(VIEW_REVIEW);
    check(32'(LEDS.review), 32'h1);
    disp(5'h03, 8'h0d);
    for (int i = 1; i <= 6; i++) begin
      press(2, TAP);
      chk_reg(REG_SLOT, 32'h7, 32'(i % 6));
    end
    @(posedge CLOCK);
    base <= 8'h1e;
    press(2, TAP);
    press(1, TAP);
    view(VIEW_LIVE);
    check(32'(LEDS.review), 32'h0);
    press(0, TAP);
    press(0, TAP);
    chk_reg(REG_SLOT, 32'h7, 32'h1);
    disp(5'h03, 8'h21);
    press(1, TAP);
    press(1, TAP);
    view(VIEW_REVIEW);
    press(1, TAP);
  endtask : s_store

  task automatic s_avg();
    press(0, HOLD);
    view(VIEW_AVG_SEL);
    flashing(5, 1'b1);
    go_slot(3'h0);
    press(0, TAP);
    go_slot(3'h1);
    press(0, TAP);
    press(0, TAP);
    chk_reg(REG_AVG_COUNT, 32'h1ff, 32'h3);
    press(0, HOLD);
    flashing(5, 1'b0);
    check(32'(LEDS.last_slot), 32'h1);
    disp(5'h03, 8'h1a);
    disp(5'h1d, 8'h34);
    @(posedge CLOCK);
    SRST <= 1'b1;
    repeat (3) @(posedge CLOCK);
    SRST <= 1'b0;
    press(1, TAP);
    go_slot(3'h5);
    disp(5'h03, 8'h1a);
    go_slot(3'h0);
    print_once(8'h00, 8'h46);
    wr(REG_CONTROL, 32'h1);
    print_once(8'h06, 8'h43);
    wr(REG_CONTROL, 32'h0);
    press(1, TAP);
  endtask : s_avg

  task automatic s_peak_level();
    @(posedge CLOCK);
    base <= 8'h32;
    press(1, HOLD);
    view(VIEW_PEAK);
    flashing(3, 1'b1);
    @(posedge CLOCK);
    base <= 8'h05;
    repeat (40) @(posedge CLOCK);
    disp(5'h03, 8'h35);
    press(0, TAP);
    press(0, TAP);
    disp(5'h03, 8'h35);
    press(1, TAP);
    press(1, HOLD);
    press(1, TAP);
    view(VIEW_LIVE);
    @(posedge CLOCK);
    LEVEL_READING <= 8'h28;
    press(3, HOLD);
    press(1, HOLD);
    flashing(2, 1'b1);
    @(posedge CLOCK);
    LEVEL_READING <= 8'h5a;
    repeat (5) @(posedge CLOCK);
    LEVEL_READING <= 8'h14;
    repeat (5) @(posedge CLOCK);
    #1;
    check(32'(LEVEL_SHOWN), 32'h5a);
    chk_reg(REG_LEVEL_PEAK, 32'hff, 32'h5a);
  endtask : s_peak_level

  task automatic s_power();
    @(posedge CLOCK);
    CHARGING <= 1'b1;
    repeat (10) @(posedge CLOCK);
    #1;
    check(32'(LEDS.charge), 32'h1);
    @(posedge CLOCK);
    CHARGE_FULL <= 1'b1;
    flashing(0, 1'b1);
    @(posedge CLOCK);
    CHARGING <= 1'b0;
    CHARGE_FULL <= 1'b0;
    BATTERY_LOW <= 1'b1;
    flashing(1, 1'b1);
    @(posedge CLOCK);
    BATTERY_LOW <= 1'b0;
    repeat (10) @(posedge CLOCK);
  endtask : s_power

  initial begin
    btn[0] = 1'b1;
    repeat (5) @(posedge CLOCK);
    SRST <= 1'b0;
    @(posedge CLOCK);
    btn[0] <= 1'b0;
    repeat (40) @(posedge CLOCK);
    s_erase();
    s_store();
    s_avg();
    s_peak_level();
    s_power();
    stop_test();
  end
endmodule : apm_panel_tb
